// *** design/dwtt_pkg.sv ***
// Package with timing constants, types and register map for the scheduler
package dwtt_pkg;
    localparam int  DWTT_NGRP      = 4;
    localparam int  DWTT_CW        = 6;
    localparam logic [5:0] DWTT_CWL_MIN    = 6'h09;
    localparam logic [5:0] DWTT_WCCD_CRC2  = 6'h06;
    localparam logic [5:0] DWTT_ONE_TCK    = 6'h01;
    localparam logic [5:0] DWTT_BEATS8     = 6'h08;
    localparam logic [5:0] DWTT_BEATS4     = 6'h04;
    localparam logic [5:0] DWTT_CRC_BEATS  = 6'h02;
    localparam logic [1:0] DWTT_BL_FIX8    = 2'h0;
    localparam logic [1:0] DWTT_BL_OTF     = 2'h1;
    localparam logic [1:0] DWTT_BL_FIXBC4  = 2'h2;
    // Register addresses
    localparam logic [3:0] DWTT_A_MODE     = 4'h0;
    localparam logic [3:0] DWTT_A_LAT      = 4'h1;
    localparam logic [3:0] DWTT_A_TWTR     = 4'h2;
    localparam logic [3:0] DWTT_A_TWTRCD   = 4'h3;
    localparam logic [3:0] DWTT_A_CMD      = 4'h4;
    localparam logic [3:0] DWTT_A_STAT     = 4'h5;
    // Command codes on the issue port
    localparam logic [1:0] DWTT_OP_NONE    = 2'h0;
    localparam logic [1:0] DWTT_OP_RD      = 2'h1;
    localparam logic [1:0] DWTT_OP_WR      = 2'h2;

    typedef struct packed {
        logic [1:0] bl_mode;
        logic       pre2;
        logic       crc_en;
        logic       dm_en;
    } dwtt_mode_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] op;
        logic [1:0] grp;
        logic       a12;
    } dwtt_cmd_t;
endpackage : dwtt_pkg

// *** design/dwtt_cnt.sv ***
// Per bank-group countdown holding cycles until the next read is allowed
`timescale 1ns/10ps
`default_nettype none
module dwtt_cnt
    import dwtt_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    output logic              zero
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } dwtt_cnt_st_t;
    dwtt_cnt_st_t st;
    dwtt_cnt_st_t next_st;

    always_comb begin
        next_st = st;
        // A later write never shortens a wait that is still running
        if (load && value >= st.cnt) begin
            next_st.cnt = value;
        end else if (st.cnt != '0) begin
            next_st.cnt = st.cnt - W'(1);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign zero = (st.cnt == '0);
endmodule : dwtt_cnt
`default_nettype wire

// *** design/dwtt_sched.sv ***
// Host-side write turnaround scheduler for a DDR4 command stream
// Summary of operation
// - In two-clock preamble mode, write latency 9 is refused as illegal.
// - Two-clock preamble with CRC forbids write-to-write spacing of six clocks.
// - Read to write gap is CL-CWL+read_burst_beats/2+1+preamble clocks.
// - Same group write to read gap is CWL+write_burst_beats/2+tWTR_L.
// - Other group write to read gap is CWL+write_burst_beats/2+tWTR_S.
// - Read beats are 8 for length-8 reads, 4 for chopped reads.
// - Write beats are 4 only with fixed chop, otherwise 8.
// - Turnaround counting starts after the last data beat, CRC included.
// - With CRC and data mask on, use the CRC-mask turnaround values.
// - After a write timing violation, full reinitialisation is required.
`timescale 1ns/10ps
`default_nettype none
module dwtt_sched
    import dwtt_pkg::*;
#(
    parameter int CW = 8
) (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       cmd_ready,
    output dwtt_cmd_t       cmd_out
);
    typedef struct packed {
        dwtt_mode_t      mode;
        logic [5:0]      cl;
        logic [5:0]      cwl;
        logic [3:0]      twtr_l;
        logic [3:0]      twtr_s;
        logic [3:0]      twtr_l_cd;
        logic [3:0]      twtr_s_cd;
        dwtt_cmd_t       pend;
        logic [CW-1:0]   rtw;
        logic [CW-1:0]   wtw;
        logic [CW-1:0]   since_wr;
        logic            wr_seen;
        logic            lat_err;
        logic            space_err;
        logic            reinit_req;
        dwtt_cmd_t       out;
        logic [7:0]      rdata;
    } dwtt_st_t;
    dwtt_st_t st;
    dwtt_st_t next_st;

    logic [DWTT_NGRP-1:0]  grp_zero;
    logic [DWTT_NGRP-1:0]  grp_load;
    logic [CW-1:0]         grp_val [DWTT_NGRP];

    function automatic logic [5:0] wr_beats(input logic [1:0] blm);
        return (blm == DWTT_BL_FIXBC4) ? DWTT_BEATS4 : DWTT_BEATS8;
    endfunction

    function automatic logic [5:0] rd_beats(input logic [1:0] blm,
                                            input logic a12);
        logic chop;
        chop = (blm == DWTT_BL_FIXBC4) || (blm == DWTT_BL_OTF && !a12);
        return chop ? DWTT_BEATS4 : DWTT_BEATS8;
    endfunction

    // Burst actually chopped on the data bus for a write
    function automatic logic wr_chop(input logic [1:0] blm, input logic a12);
        if (blm == DWTT_BL_FIXBC4) begin
            return 1'b1;
        end
        return (blm == DWTT_BL_OTF) && !a12;
    endfunction

    logic       lat_bad;
    logic       issue;
    logic       can_go;
    logic [5:0] pre_clk;
    logic [3:0] wtr_l;
    logic [3:0] wtr_s;
    logic [CW-1:0] rtw_val;
    logic [CW-1:0] wtr_base;

    always_comb begin
        pre_clk = DWTT_ONE_TCK + {5'h00, st.mode.pre2};
        lat_bad = st.mode.pre2 && (st.cwl <= DWTT_CWL_MIN);
        wtr_l = (st.mode.crc_en && st.mode.dm_en) ? st.twtr_l_cd
                                                  : st.twtr_l;
        wtr_s = (st.mode.crc_en && st.mode.dm_en) ? st.twtr_s_cd
                                                  : st.twtr_s;
        rtw_val = CW'(st.cl - st.cwl
                      + (rd_beats(st.mode.bl_mode, st.pend.a12) >> 1)
                      + DWTT_ONE_TCK + pre_clk);
        // Counted from the edge after the final beat, CRC beats included
        wtr_base = CW'(st.cwl + (wr_beats(st.mode.bl_mode) >> 1)
                       + (st.mode.crc_en ? DWTT_CRC_BEATS >> 1 : 6'h00)
                       + DWTT_ONE_TCK);
        can_go = 1'b0;
        if (st.pend.valid && !lat_bad && !st.reinit_req) begin
            if (st.pend.op == DWTT_OP_RD) begin
                can_go = grp_zero[st.pend.grp];
            end else begin
                can_go = (st.rtw == '0) &&
                    !(st.mode.pre2 && st.mode.crc_en && st.wr_seen &&
                      st.since_wr == CW'(DWTT_WCCD_CRC2 - DWTT_ONE_TCK));
            end
        end
        issue = can_go && cmd_ready;
        for (int g = 0; g < DWTT_NGRP; g++) begin
            grp_load[g] = issue && (st.pend.op == DWTT_OP_WR);
            grp_val[g]  = wtr_base + CW'((g == int'(st.pend.grp)) ? wtr_l
                                                                 : wtr_s);
        end
    end

    always_comb begin
        next_st = st;
        next_st.out = '0;
        next_st.lat_err = lat_bad;
        if (st.rtw != '0) begin
            next_st.rtw = st.rtw - CW'(1);
        end
        if (st.since_wr != '1) begin
            next_st.since_wr = st.since_wr + CW'(1);
        end
        if (issue) begin
            next_st.out = st.pend;
            next_st.out.a12 = !wr_chop(st.mode.bl_mode, st.pend.a12);
            next_st.pend.valid = 1'b0;
            if (st.pend.op == DWTT_OP_RD) begin
                next_st.rtw = rtw_val;
            end else begin
                next_st.since_wr = '0;
                next_st.wr_seen = 1'b1;
            end
        end
        if (wr) begin
            unique case (addr)
                DWTT_A_MODE: begin
                    next_st.mode = dwtt_mode_t'(wdata[4:0]);
                    // Clearing the flag after a violation models reinit
                    if (wdata[7]) begin
                        next_st.reinit_req = 1'b0;
                        next_st.space_err  = 1'b0;
                    end
                end
                DWTT_A_LAT: begin
                    next_st.cwl = {2'h0, wdata[3:0]} + DWTT_CWL_MIN;
                    next_st.cl  = {2'h0, wdata[7:4]} + DWTT_CWL_MIN;
                end
                DWTT_A_TWTR: begin
                    next_st.twtr_s = wdata[3:0];
                    next_st.twtr_l = wdata[7:4];
                end
                DWTT_A_TWTRCD: begin
                    next_st.twtr_s_cd = wdata[3:0];
                    next_st.twtr_l_cd = wdata[7:4];
                end
                DWTT_A_CMD: begin
                    if (st.pend.valid && !issue) begin
                        next_st.space_err  = 1'b1;
                        next_st.reinit_req = 1'b1;
                    end else begin
                        next_st.pend.valid = wdata[0];
                        next_st.pend.op    = wdata[2:1];
                        next_st.pend.grp   = wdata[4:3];
                        next_st.pend.a12   = wdata[5];
                    end
                end
                default: begin
                end
            endcase
        end
        next_st.rdata = '0;
        if (rd) begin
            unique case (addr)
                DWTT_A_MODE:   next_st.rdata = {st.reinit_req, 2'h0, st.mode};
                DWTT_A_LAT:    next_st.rdata = {st.cl[3:0] - DWTT_CWL_MIN[3:0],
                                                st.cwl[3:0] - DWTT_CWL_MIN[3:0]};
                DWTT_A_TWTR:   next_st.rdata = {st.twtr_l, st.twtr_s};
                DWTT_A_TWTRCD: next_st.rdata = {st.twtr_l_cd, st.twtr_s_cd};
                DWTT_A_CMD:    next_st.rdata = {2'h0, st.pend.a12, st.pend.grp,
                                                st.pend.op, st.pend.valid};
                DWTT_A_STAT:   next_st.rdata = {st.reinit_req, st.space_err,
                                                st.lat_err, 1'b0, grp_zero};
                default:       next_st.rdata = '0;
            endcase
        end
    end

    for (genvar g = 0; g < DWTT_NGRP; g++) begin : g_grp
        dwtt_cnt #(.W(CW)) u_cnt (
            .sys_clk (sys_clk),
            .rst     (rst),
            .load    (grp_load[g]),
            .value   (grp_val[g]),
            .zero    (grp_zero[g])
        );
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata   = st.rdata;
    assign cmd_out = st.out;
endmodule : dwtt_sched
`default_nettype wire

// *** sim/dwtt_properties.sv ***
// Checker for command spacing of the turnaround scheduler
`timescale 1ns/10ps
`default_nettype none
module dwtt_properties
    import dwtt_pkg::*;
#(
    parameter int CW = 8
) (
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       cmd_ready,
    input wire dwtt_cmd_t  cmd_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [7:0] md, lat, tw, twc, wg, rg, tws;
    logic [3:0] lwb, lrb, tl;
    logic [1:0] lg;
    logic       wv, rv, sg;
    int         nw, nr;
    assign wv = cmd_out.valid && cmd_out.op == DWTT_OP_WR;
    assign rv = cmd_out.valid && cmd_out.op == DWTT_OP_RD;
    assign sg = cmd_out.grp == lg;
    assign tws = (md[1] && md[0]) ? twc : tw;
    assign tl = sg ? tws[7:4] : tws[3:0];
    always_comb begin
        nw = int'(lat[7:4]) - int'(lat[3:0]) + int'(lrb) / 2 + 2 + int'(md[2]);
        nr = 10 + int'(lat[3:0]) + int'(lwb) / 2 + int'(md[1]) + int'(tl);
    end
    // Shadow of the settings plus cycles since the last issued write and the last issued read
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {md, lat, tw, twc} <= '0;
            {wg, rg} <= 16'hffff;
            {lwb, lrb, lg} <= '0;
        end else begin
            if (wr) begin
                case (addr)
                    DWTT_A_MODE:   md <= wdata;
                    DWTT_A_LAT:    lat <= wdata;
                    DWTT_A_TWTR:   tw <= wdata;
                    DWTT_A_TWTRCD: twc <= wdata;
                    default: ;
                endcase
            end
            wg <= wv ? 8'h01 : wg + {7'h0, wg != 8'hff};
            rg <= rv ? 8'h01 : rg + {7'h0, rg != 8'hff};
            if (wv) begin
                lg <= cmd_out.grp;
                lwb <= (md[4:3] == DWTT_BL_FIXBC4) ? 4'h4 : 4'h8;
            end
            if (rv) begin
                lrb <= cmd_out.a12 ? 4'h8 : 4'h4;
            end
        end
    end
    a_lat_block:
        assert property ((md[2] && lat[3:0] == 4'h0) [*2] |-> !cmd_out.valid)
        else $error("command issued with illegal write latency");
    a_wr_spacing:
        assert property (wv && md[2] && md[1] |-> wg != 8'h06)
        else $error("write issued six cycles after a write");
    a_rd_to_wr:
        assert property (wv |-> int'(rg) >= nw)
        else $error("write too soon after read");
    a_wr_rd_same:
        assert property (rv && sg |-> int'(wg) >= nr)
        else $error("read too soon after write in same group");
    a_wr_rd_other:
        assert property (rv && !sg |-> int'(wg) >= nr)
        else $error("read too soon after write in other group");
    a_ready_gate:
        assert property (cmd_out.valid |-> $past(cmd_ready))
        else $error("command issued without ready");
    a_issue_pulse:
        assert property (cmd_out.valid |=> !cmd_out.valid)
        else $error("command held longer than one cycle");
    a_rdata_quiet:
        assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside its cycle");
    c_wr_pair: cover property (wv && md[2] && md[1] && wg < 8'h20);
    c_rd_same: cover property (rv && sg && wg < 8'h40);
    c_blocked: cover property (md[2] && lat[3:0] == 4'h0 && !cmd_out.valid);
endmodule // dwtt_properties
`default_nettype wire

// *** sim/dwtt_dev_model.sv ***
// Behavioural device model answering the command port
`timescale 1ns/10ps
`default_nettype none
module dwtt_dev_model
    import dwtt_pkg::*;
(
    input  wire logic      sys_clk,
    input  wire logic      rst,
    input  wire logic      slow,
    input  wire dwtt_cmd_t cmd_out,
    output logic           cmd_ready
);
    logic [1:0] ph;
    logic [3:0] beats;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ph <= 2'h0;
            beats <= 4'h0;
        end else begin
            ph <= ph + 2'h1;
            if (cmd_out.valid) begin
                beats <= cmd_out.a12 ? 4'h8 : 4'h4;
            end
        end
    end
    // No data is stored, so a strobe fault cannot spread
    // Slow mode still answers every fourth cycle, so it never hangs
    assign cmd_ready = !rst && (!slow || ph == 2'h3);
endmodule // dwtt_dev_model
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the write turnaround scheduler
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import dwtt_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        rd_d = 1'b0;
    logic        slow = 1'b0;
    logic [1:0]  bl = 2'h0;
    logic [31:0] seed = 32'he225;
    logic        cmd_ready;
    logic [7:0]  rdata;
    dwtt_cmd_t   cmd_out;
    logic [15:0] rq[$];
    logic [5:0]  cq[$];
    int          miscompares = 0;
    int          comparisons = 0;
    always #25 sys_clk = ~sys_clk;
    dwtt_sched #(.CW(8)) i_dwtt_sched (
        .sys_clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .cmd_ready, .cmd_out
    );
    dwtt_dev_model i_dwtt_dev_model (
        .sys_clk, .rst, .slow, .cmd_out, .cmd_ready
    );
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic ea(input logic [1:0] b, input logic a);
        return b == DWTT_BL_FIX8 || (b == DWTT_BL_OTF && a);
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rreg(input logic [3:0] a, input logic [7:0] m,
                        input logic [7:0] e);
        addr <= a;
        rd <= 1'b1;
        rq.push_back({m, e});
        @(posedge sys_clk);
        rd <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic cmd(input logic [1:0] op, input logic [1:0] g,
                       input logic a, input logic nt);
        if (nt) begin
            cq.push_back({1'b1, op, g, ea(bl, a)});
        end
        wreg(DWTT_A_CMD, {2'h0, a, g, op, 1'b1});
        for (int n = 0; n < 400 && cq.size() > 0; n++) begin
            @(posedge sys_clk);
        end
        chk(8'(cq.size()), 8'h00);
    endtask
    // Results are matched against the oldest pending note
    always @(posedge sys_clk) begin
        logic [15:0] n;
        rd_d <= rd;
        if (rd_d) begin
            n = rq.pop_front();
            chk(rdata & n[15:8], n[7:0]);
        end
        if (cmd_out.valid) begin
            chk({2'h0, cmd_out}, cq.size() > 0 ? {2'h0, cq.pop_front()} : 8'h00);
        end
    end
    initial begin
        repeat (40000) @(posedge sys_clk);
        miscompares++;
        test_done();
    end
    initial begin
        logic [3:0] cw;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rreg(DWTT_A_MODE, 8'hff, 8'h00);
        rreg(4'hf, 8'hff, 8'h00);
        rreg(DWTT_A_STAT, 8'he0, 8'h00);
        for (int m = 0; m < 12; m++) begin
            seed = xs(seed);
            bl = 2'(m % 3);
            cw = 4'h1 + {2'h0, seed[9:8]};
            slow <= seed[12];
            wreg(DWTT_A_MODE, {3'h0, bl, seed[2:0]});
            wreg(DWTT_A_LAT, {cw + {2'h0, seed[11:10]}, cw});
            rreg(DWTT_A_LAT, 8'hff, {cw + {2'h0, seed[11:10]}, cw});
            wreg(DWTT_A_TWTR, seed[23:16]);
            rreg(DWTT_A_TWTR, 8'hff, seed[23:16]);
            wreg(DWTT_A_TWTRCD, seed[31:24]);
            repeat (256) @(posedge sys_clk);
            repeat (6) begin
                seed = xs(seed);
                cmd(seed[0] ? DWTT_OP_RD : DWTT_OP_WR, seed[2:1], seed[3], 1'b1);
            end
        end
        bl = DWTT_BL_FIX8;
        wreg(DWTT_A_MODE, 8'h04);
        wreg(DWTT_A_LAT, 8'h20);
        repeat (256) @(posedge sys_clk);
        cmd(DWTT_OP_WR, 2'h1, 1'b0, 1'b0);
        repeat (12) @(posedge sys_clk);
        rreg(DWTT_A_STAT, 8'h20, 8'h20);
        cmd(DWTT_OP_RD, 2'h2, 1'b0, 1'b0);
        rreg(DWTT_A_STAT, 8'hc0, 8'hc0);
        // Clear the errors first: the pending write stays held until the latency is raised
        wreg(DWTT_A_MODE, 8'h84);
        rreg(DWTT_A_STAT, 8'hc0, 8'h00);
        cq.push_back({1'b1, DWTT_OP_WR, 2'h1, 1'b1});
        wreg(DWTT_A_LAT, 8'h21);
        repeat (60) @(posedge sys_clk);
        chk(8'(cq.size()), 8'h00);
        test_done();
    end
endmodule // tb_top
bind dwtt_sched dwtt_properties #(.CW(CW)) i_dwtt_properties (
    .sys_clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .cmd_ready, .cmd_out
);
`default_nettype wire
